// ### inc/oag_pkg.sv
// Shared constants and types for the operand address generator
package oag_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_PC = 8'h08;
  localparam logic [7:0] OFS_PAGE = 8'h0c;
  localparam logic [7:0] OFS_PTR0 = 8'h10;
  localparam logic [7:0] OFS_ACC = 8'h20;
  localparam logic [7:0] OFS_EA = 8'h24;
  localparam logic [7:0] OFS_OPND = 8'h28;
  localparam logic [7:0] OFS_INFO = 8'h2c;
  localparam logic [7:0] OFS_STACK = 8'h30;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CTRL_START_BIT = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_ERR_BIT = 2;
  localparam int STACK_PULL_BIT = 8;
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;

  // ****************************************
  // Addressing modes written to CTRL[2:0]
  // ****************************************
  localparam logic [2:0] MODE_IMM8 = 3'h0;
  localparam logic [2:0] MODE_IMM16 = 3'h1;
  localparam logic [2:0] MODE_DIRECT = 3'h2;
  localparam logic [2:0] MODE_EXT = 3'h3;
  localparam logic [2:0] MODE_INDEXED = 3'h4;

  // ****************************************
  // Indexed variant codes (postbyte bits 3..0)
  // ****************************************
  localparam logic [3:0] IX_INC1 = 4'h0;
  localparam logic [3:0] IX_INC2 = 4'h1;
  localparam logic [3:0] IX_DEC1 = 4'h2;
  localparam logic [3:0] IX_DEC2 = 4'h3;
  localparam logic [3:0] IX_ZERO = 4'h4;
  localparam logic [3:0] IX_ACC2 = 4'h5;
  localparam logic [3:0] IX_ACC1 = 4'h6;
  localparam logic [3:0] IX_OFS8 = 4'h8;
  localparam logic [3:0] IX_OFS16 = 4'h9;
  localparam logic [3:0] IX_DACC = 4'hb;
  localparam logic [3:0] IX_PC8 = 4'hc;
  localparam logic [3:0] IX_PC16 = 4'hd;
  localparam logic [3:0] IX_EXTIND = 4'hf;

  // ****************************************
  // Extra cycle counts
  // ****************************************
  localparam logic [3:0] CYC_ZERO = 4'h0;
  localparam logic [3:0] CYC_SHORT = 4'h1;
  localparam logic [3:0] CYC_LONG = 4'h4;
  localparam logic [3:0] CYC_STEP1 = 4'h2;
  localparam logic [3:0] CYC_STEP2 = 4'h3;
  localparam logic [3:0] CYC_PC16 = 4'h5;
  localparam logic [3:0] CYC_EXTIND = 4'h2;
  localparam logic [3:0] CYC_INDIR = 4'h3;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_OPND = 6'b000010,
    ST_POST = 6'b000100,
    ST_OFFS = 6'b001000,
    ST_CALC = 6'b010000,
    ST_INDR = 6'b100000
  } oag_state_e;

  typedef struct packed {
    logic rd;
    logic [15:0] addr;
  } oag_mem_s;

endpackage

// ### src/oag_core.sv
// Operand effective-address generator with Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
module oag_core
  import oag_pkg::*;
#(
  parameter int ADDR_W = 6
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic mem_rd_out,
  output logic [15:0] mem_addr_out,
  input wire logic [7:0] mem_data_in,
  input wire logic mem_valid_in,
  output logic busy_out
);

  // ****************************************
  // Elaboration check
  // ****************************************
  if (ADDR_W < 6 || ADDR_W > 8) begin : g_bad_addr_w
    $error("ADDR_W must be 6 to 8");
  end

  // ****************************************
  // State
  // ****************************************
  oag_state_e state_reg, state_next;
  oag_mem_s mem_reg, mem_next;
  logic [1:0] cnt_reg, cnt_next;
  logic [15:0] sh_reg, sh_next;
  logic [2:0] mode_reg, mode_next;
  logic [15:0] pc_reg, pc_next;
  logic [7:0] page_reg, page_next;
  logic [15:0] ptr_reg [4];
  logic [15:0] ptr_next [4];
  logic [7:0] acc1_reg, acc1_next;
  logic [7:0] acc2_reg, acc2_next;
  logic [15:0] ea_reg, ea_next;
  logic [15:0] opnd_reg, opnd_next;
  logic [15:0] ofs_reg, ofs_next;
  logic [7:0] post_reg, post_next;
  logic [3:0] cyc_reg, cyc_next;
  logic done_reg, done_next;
  logic err_reg, err_next;
  logic [3:0] smask_reg, smask_next;
  logic spull_reg, spull_next;
  logic wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;
  logic busy_reg, busy_next;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Stack order list: codes 0 first acc, 1 second acc, 2 first index, 3 second index
  function automatic logic [10:0] stack_seq(input logic [3:0] mask, input logic pull);
    logic [7:0] seq;
    logic [2:0] n;
    logic [1:0] code;
    seq = 8'h00;
    n = 3'h0;
    code = 2'h0;
    for (int i = 0; i < 4; i++) begin
      code = pull ? 2'(i) : 2'(3 - i);
      if (mask[code]) begin
        seq[2*n[1:0] +: 2] = code;
        n = n + 3'h1;
      end
    end
    return {n, seq};
  endfunction

  // ****************************************
  // Bus decode and fetch signals
  // ****************************************
  logic [7:0] bus_ofs;
  logic req;
  logic bus_take;
  logic byte_in;
  logic last_byte;
  logic [15:0] word_in;
  logic [15:0] base;
  logic [15:0] sum;
  logic [31:0] wv;
  logic [10:0] sseq;

  always_comb begin
    bus_ofs = 8'({avs_address_in[ADDR_W-1:2], 2'b00});
    req = avs_read_in || avs_write_in;
    bus_take = req && !wait_reg;
    byte_in = mem_reg.rd && mem_valid_in;
    last_byte = byte_in && (cnt_reg == 2'h1);
    word_in = {sh_reg[7:0], mem_data_in};
    sseq = stack_seq(smask_reg, spull_reg);
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    state_next = state_reg;
    mem_next = mem_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    mode_next = mode_reg;
    pc_next = pc_reg;
    page_next = page_reg;
    ptr_next = ptr_reg;
    acc1_next = acc1_reg;
    acc2_next = acc2_reg;
    ea_next = ea_reg;
    opnd_next = opnd_reg;
    ofs_next = ofs_reg;
    post_next = post_reg;
    cyc_next = cyc_reg;
    done_next = done_reg;
    err_next = err_reg;
    smask_next = smask_reg;
    spull_next = spull_reg;
    wait_next = !(req && wait_reg);
    rdata_next = rdata_reg;
    base = WORD_RST;
    sum = WORD_RST;
    wv = 32'h0;

    // Register reads, answered one cycle after the request
    if (avs_read_in && wait_reg) begin
      rdata_next = 32'h0;
      if (bus_ofs == OFS_CTRL) begin
        rdata_next = {29'h0, mode_reg};
      end else if (bus_ofs == OFS_STAT) begin
        rdata_next = {29'h0, err_reg, done_reg, busy_reg};
      end else if (bus_ofs == OFS_PC) begin
        rdata_next = {16'h0, pc_reg};
      end else if (bus_ofs == OFS_PAGE) begin
        rdata_next = {24'h0, page_reg};
      end else if (bus_ofs[7:4] == OFS_PTR0[7:4]) begin
        rdata_next = {16'h0, ptr_reg[bus_ofs[3:2]]};
      end else if (bus_ofs == OFS_ACC) begin
        rdata_next = {16'h0, acc2_reg, acc1_reg};
      end else if (bus_ofs == OFS_EA) begin
        rdata_next = {16'h0, ea_reg};
      end else if (bus_ofs == OFS_OPND) begin
        rdata_next = {16'h0, opnd_reg};
      end else if (bus_ofs == OFS_INFO) begin
        rdata_next = {16'h0, post_reg, 4'h0, cyc_reg};
      end else if (bus_ofs == OFS_STACK) begin
        rdata_next = {16'h0, smask_reg, 1'b0, sseq};
        rdata_next[STACK_PULL_BIT + 7] = spull_reg;
      end
    end

    // Register writes; operand-side state is frozen while busy
    if (avs_write_in && bus_take) begin
      if (bus_ofs == OFS_CTRL) begin
        wv = merge({29'h0, mode_reg}, avs_writedata_in, avs_byteenable_in);
        if (!busy_reg) begin
          mode_next = wv[2:0];
        end
        // Start of a new operand sequence, entered only from idle
        if (!busy_reg && wv[CTRL_START_BIT] && avs_byteenable_in[1]) begin
          mem_next.rd = 1'b1;
          mem_next.addr = pc_reg;
          sh_next = WORD_RST;
          cyc_next = CYC_ZERO;
          post_next = 8'h00;
          ea_next = pc_reg;
          done_next = 1'b0;
          err_next = 1'b0;
          cnt_next = (wv[2:0] == MODE_IMM16 || wv[2:0] == MODE_EXT) ? 2'h2 : 2'h1;
          state_next = (wv[2:0] == MODE_INDEXED) ? ST_POST : ST_OPND;
        end
      end else if (bus_ofs == OFS_STAT) begin
        if (avs_byteenable_in[0] && avs_writedata_in[STAT_DONE_BIT]) begin
          done_next = 1'b0;
        end
        if (avs_byteenable_in[0] && avs_writedata_in[STAT_ERR_BIT]) begin
          err_next = 1'b0;
        end
      end else if (busy_reg) begin
        wv = 32'h0;
      end else if (bus_ofs == OFS_PC) begin
        wv = merge({16'h0, pc_reg}, avs_writedata_in, avs_byteenable_in);
        pc_next = wv[15:0];
      end else if (bus_ofs == OFS_PAGE) begin
        wv = merge({24'h0, page_reg}, avs_writedata_in, avs_byteenable_in);
        page_next = wv[7:0];
      end else if (bus_ofs[7:4] == OFS_PTR0[7:4]) begin
        wv = merge({16'h0, ptr_reg[bus_ofs[3:2]]}, avs_writedata_in, avs_byteenable_in);
        ptr_next[bus_ofs[3:2]] = wv[15:0];
      end else if (bus_ofs == OFS_ACC) begin
        wv = merge({16'h0, acc2_reg, acc1_reg}, avs_writedata_in, avs_byteenable_in);
        acc1_next = wv[7:0];
        acc2_next = wv[15:8];
      end else if (bus_ofs == OFS_STACK) begin
        wv = merge({16'h0, 7'h0, spull_reg, 4'h0, smask_reg}, avs_writedata_in,
                   avs_byteenable_in);
        smask_next = wv[3:0];
        spull_next = wv[STACK_PULL_BIT];
      end
    end

    // Byte fetch engine shared by every fetching state
    if (byte_in) begin
      sh_next = word_in;
      mem_next.addr = mem_reg.addr + 16'h1;
      cnt_next = cnt_reg - 2'h1;
      if (last_byte) begin
        mem_next.rd = 1'b0;
      end
    end

    case (state_reg)
      ST_OPND: begin
        if (last_byte) begin
          pc_next = mem_reg.addr + 16'h1;
          state_next = ST_IDLE;
          done_next = 1'b1;
          if (mode_reg == MODE_DIRECT) begin
            ea_next = {page_reg, mem_data_in};
          end else if (mode_reg == MODE_EXT) begin
            ea_next = word_in;
          end else begin
            opnd_next = word_in;
          end
        end
      end
      ST_POST: begin
        if (last_byte) begin
          post_next = mem_data_in;
          pc_next = mem_reg.addr + 16'h1;
          sh_next = WORD_RST;
          state_next = ST_CALC;
          cyc_next = CYC_SHORT;
          if (mem_data_in[7]) begin
            case (mem_data_in[3:0])
              IX_INC1, IX_DEC1: cyc_next = CYC_STEP1;
              IX_INC2, IX_DEC2: cyc_next = CYC_STEP2;
              IX_ZERO: cyc_next = CYC_ZERO;
              IX_ACC1, IX_ACC2, IX_OFS8, IX_PC8: cyc_next = CYC_SHORT;
              IX_OFS16, IX_DACC: cyc_next = CYC_LONG;
              IX_PC16: cyc_next = CYC_PC16;
              IX_EXTIND: cyc_next = CYC_EXTIND;
              default: cyc_next = CYC_ZERO;
            endcase
            if (mem_data_in[4]) begin
              cyc_next = cyc_next + CYC_INDIR;
            end
            if (mem_data_in[3:0] == IX_OFS8 || mem_data_in[3:0] == IX_PC8) begin
              cnt_next = 2'h1;
              mem_next.rd = 1'b1;
              state_next = ST_OFFS;
            end else if (mem_data_in[3:0] == IX_OFS16 || mem_data_in[3:0] == IX_PC16
                         || mem_data_in[3:0] == IX_EXTIND) begin
              cnt_next = 2'h2;
              mem_next.rd = 1'b1;
              state_next = ST_OFFS;
            end
            // Undefined codes and by-one indirect are refused
            if (mem_data_in[3:0] == 4'h7 || mem_data_in[3:0] == 4'ha
                || mem_data_in[3:0] == 4'he
                || (mem_data_in[3:0] == IX_EXTIND && !mem_data_in[4])
                || (mem_data_in[4] && (mem_data_in[3:0] == IX_INC1
                                       || mem_data_in[3:0] == IX_DEC1))) begin
              err_next = 1'b1;
              mem_next.rd = 1'b0;
              cnt_next = 2'h0;
              state_next = ST_IDLE;
            end
          end
        end
      end
      ST_OFFS: begin
        if (last_byte) begin
          pc_next = mem_reg.addr + 16'h1; // Counter-relative base is past the offset
          ofs_next = (cnt_reg == 2'h1 && (post_reg[3:0] == IX_OFS8 || post_reg[3:0] == IX_PC8))
                     ? {{8{mem_data_in[7]}}, mem_data_in} : word_in;
          state_next = ST_CALC;
        end
      end
      ST_CALC: begin
        base = ptr_reg[post_reg[6:5]];
        sum = base;
        if (!post_reg[7]) begin
          sum = base + {{11{post_reg[4]}}, post_reg[4:0]};
        end else begin
          case (post_reg[3:0])
            IX_INC1: ptr_next[post_reg[6:5]] = base + 16'h1;
            IX_INC2: ptr_next[post_reg[6:5]] = base + 16'h2;
            IX_DEC1: begin
              sum = base - 16'h1;
              ptr_next[post_reg[6:5]] = sum;
            end
            IX_DEC2: begin
              sum = base - 16'h2;
              ptr_next[post_reg[6:5]] = sum;
            end
            IX_ACC1: sum = base + {{8{acc1_reg[7]}}, acc1_reg};
            IX_ACC2: sum = base + {{8{acc2_reg[7]}}, acc2_reg};
            IX_DACC: sum = base + {acc1_reg, acc2_reg};
            IX_OFS8, IX_OFS16: sum = base + ofs_reg;
            IX_PC8, IX_PC16: sum = pc_reg + ofs_reg;
            IX_EXTIND: sum = ofs_reg;
            default: sum = base;
          endcase
        end
        if (post_reg[7] && post_reg[4]) begin
          mem_next.addr = sum;
          mem_next.rd = 1'b1;
          cnt_next = 2'h2;
          state_next = ST_INDR;
        end else begin
          ea_next = sum;
          done_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
      ST_INDR: begin
        if (last_byte) begin
          ea_next = word_in;
          done_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        // Starts come only from the register write path above; keep its choice
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_comb begin
    busy_next = (state_next != ST_IDLE);
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_reg <= ST_IDLE;
      mem_reg <= '0;
      cnt_reg <= 2'h0;
      sh_reg <= WORD_RST;
      mode_reg <= MODE_IMM8;
      pc_reg <= WORD_RST;
      page_reg <= PAGE_RST;
      for (int i = 0; i < 4; i++) begin
        ptr_reg[i] <= WORD_RST;
      end
      acc1_reg <= 8'h00;
      acc2_reg <= 8'h00;
      ea_reg <= WORD_RST;
      opnd_reg <= WORD_RST;
      ofs_reg <= WORD_RST;
      post_reg <= 8'h00;
      cyc_reg <= CYC_ZERO;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      smask_reg <= 4'h0;
      spull_reg <= 1'b0;
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      mem_reg <= mem_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      mode_reg <= mode_next;
      pc_reg <= pc_next;
      page_reg <= page_next;
      ptr_reg <= ptr_next;
      acc1_reg <= acc1_next;
      acc2_reg <= acc2_next;
      ea_reg <= ea_next;
      opnd_reg <= opnd_next;
      ofs_reg <= ofs_next;
      post_reg <= post_next;
      cyc_reg <= cyc_next;
      done_reg <= done_next;
      err_reg <= err_next;
      smask_reg <= smask_next;
      spull_reg <= spull_next;
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
      busy_reg <= busy_next;
    end
  end

  always_comb begin
    avs_readdata_out = rdata_reg;
    avs_waitrequest_out = wait_reg;
    mem_rd_out = mem_reg.rd;
    mem_addr_out = mem_reg.addr;
    busy_out = busy_reg;
  end

endmodule // oag_core
`default_nettype wire

// ### bench/oag_core_monitor.sv
// Port checker for the operand address generator
`timescale 1ns/1ps
`default_nettype none
module oag_core_monitor
  import oag_pkg::*;
#(
  parameter int ADDR_W = 6
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic avs_waitrequest_out,
  input wire logic mem_rd_out,
  input wire logic [15:0] mem_addr_out,
  input wire logic mem_valid_in,
  input wire logic busy_out
);
  logic go;
  logic wr_ctrl;
  logic [2:0] mode_reg, mode_next;
  logic [3:0] cnt_reg, cnt_next;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // ****
  // Mode of the running sequence and bytes it fetched
  // ****
  // Mode lane and start lane are enabled separately, as in the design
  assign wr_ctrl = avs_write_in && !avs_waitrequest_out && !busy_out
    && avs_address_in[ADDR_W-1:2] == OFS_CTRL[ADDR_W-1:2];
  assign go = wr_ctrl && avs_byteenable_in[1] && avs_writedata_in[CTRL_START_BIT];
  always_comb begin
    mode_next = (wr_ctrl && avs_byteenable_in[0]) ? avs_writedata_in[2:0] : mode_reg;
    cnt_next = go ? 4'h0 : cnt_reg + {3'h0, mem_rd_out & mem_valid_in};
  end
  always_ff @(posedge clk_in) begin
    mode_reg <= rst_n_in ? mode_next : MODE_IMM8;
    cnt_reg <= rst_n_in ? cnt_next : 4'h0;
  end
  // ****
  // Properties
  // ****
  sequence s_req;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence s_ans;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence
  property p_wait;
    s_req |=> s_ans;
  endproperty
  property p_hold;
    mem_rd_out && !mem_valid_in |=> mem_rd_out && $stable(mem_addr_out);
  endproperty
  property p_fetch;
    mem_rd_out |-> busy_out;
  endproperty
  property p_start;
    go |-> ##[1:2] busy_out;
  endproperty
  property p_end;
    $rose(busy_out) |-> ##[1:200] !busy_out;
  endproperty
  property p_ext;
    $fell(busy_out) && mode_reg == MODE_EXT |-> cnt_reg == 4'h2;
  endproperty
  property p_dir;
    $fell(busy_out) && mode_reg == MODE_DIRECT |-> cnt_reg == 4'h1;
  endproperty
  property p_imm;
    $fell(busy_out) && mode_reg < MODE_DIRECT |-> cnt_reg == (mode_reg[0] ? 4'h2 : 4'h1);
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer not one cycle");
  a_hold: assert property (p_hold) else $error("fetch moved before taken");
  a_fetch: assert property (p_fetch) else $error("fetch while idle");
  a_start: assert property (p_start) else $error("start ignored");
  a_end: assert property (p_end) else $error("sequence never ends");
  a_ext: assert property (p_ext) else $error("extended byte count");
  a_dir: assert property (p_dir) else $error("direct byte count");
  a_imm: assert property (p_imm) else $error("immediate byte count");
endmodule // oag_core_monitor
bind oag_core oag_core_monitor #(.ADDR_W(ADDR_W)) u_mon (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
  .avs_waitrequest_out(avs_waitrequest_out),
  .mem_rd_out(mem_rd_out), .mem_addr_out(mem_addr_out), .mem_valid_in(mem_valid_in),
  .busy_out(busy_out));
`default_nettype wire

// ### bench/oag_mem_model.sv
// Program memory model answering byte fetches
`timescale 1ns/1ps
`default_nettype none
module oag_mem_model (
  input wire logic clk_in,
  input wire logic slow_in,
  input wire logic mem_rd_in,
  input wire logic [15:0] mem_addr_in,
  output logic [7:0] mem_data_out,
  output logic mem_valid_out
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_reg = 8'h00;
  logic [1:0] gap_reg = 2'h0;
  assign mem_valid_out = mem_rd_in && gap_reg == 2'h0;
  // Idle data is the inverse of the last byte so stale values never match
  assign mem_data_out = mem_valid_out ? mem[mem_addr_in] : ~last_reg;
  always_ff @(posedge clk_in) begin
    if (mem_valid_out) begin
      last_reg <= mem[mem_addr_in];
      gap_reg <= slow_in ? 2'h2 : 2'h0;
    end else if (gap_reg != 2'h0) begin
      gap_reg <= gap_reg - 2'h1;
    end
  end
endmodule // oag_mem_model
`default_nettype wire

// ### bench/oag_core_test.sv
// Self-checking bench for the operand address generator
`timescale 1ns/1ps
`default_nettype none
module oag_core_test
  import oag_pkg::*;
;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic rd = 1'b0, wr = 1'b0, chk = 1'b0, slow = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [31:0] wd = 32'h0, rdata;
  logic wreq, mrd, mval, busy;
  logic [15:0] maddr, pc, p, acc;
  logic [7:0] mdata, b;
  logic [15:0] pr [4];
  logic [31:0] expq [$], mskq [$];
  int num_errors = 0, num_checks = 0, seed = 22;
  oag_core #(.ADDR_W(6)) u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hf),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .mem_rd_out(mrd),
    .mem_addr_out(maddr), .mem_data_in(mdata), .mem_valid_in(mval), .busy_out(busy));
  oag_mem_model u_mem (.clk_in(clk_in), .slow_in(slow), .mem_rd_in(mrd),
    .mem_addr_in(maddr), .mem_data_out(mdata), .mem_valid_out(mval));
  initial forever #2.5 clk_in = ~clk_in;
  // ****
  // Reporting and bus tasks
  // ****
  task automatic results();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic fail(input string m);
    num_errors++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
    num_checks++;
    if ((g & m) !== (e & m)) fail($sformatf("read %h expected %h", g, e));
  endtask
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
    int n = 0;
    @(posedge clk_in);
    rd <= !w;
    wr <= w;
    adr <= a[5:0];
    wd <= d;
    chk <= c;
    do begin
      @(posedge clk_in);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) begin
      fail("bus hang");
      results();
    end
    rd <= 1'b0;
    wr <= 1'b0;
    chk <= 1'b0;
  endtask
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 1'b0);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    expq.push_back(e);
    mskq.push_back(m);
    bus(1'b0, a, 32'h0, 1'b1);
  endtask
  always @(posedge clk_in) begin
    if (rd && chk && wreq === 1'b0) begin
      if (expq.size() == 0) fail("read with no note");
      else cmp(rdata, expq.pop_front(), mskq.pop_front());
    end
  end
  task automatic run(input logic [2:0] m);
    int n = 0;
    wr32(OFS_CTRL, {24'h1, 5'h0, m});
    repeat (2) @(posedge clk_in);
    while (busy !== 1'b0 && n < 300) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 300) begin
      fail("busy hang");
      results();
    end
  endtask
  task automatic put_w(input logic [15:0] a, input logic [15:0] w);
    u_mem.mem[a] = w[15:8];
    u_mem.mem[a + 16'h1] = w[7:0];
  endtask
  task automatic ix(input logic [7:0] pb, input int nob, input logic [15:0] o,
      input logic [15:0] ea, input logic [3:0] cyc, input logic [15:0] np, input logic er);
    logic [7:0] pa;
    pa = OFS_PTR0 + {4'h0, pb[6:5], 2'b00};
    wr32(pa, {16'h0, pr[pb[6:5]]});
    u_mem.mem[pc] = pb;
    put_w(pc + 16'h1, nob == 2 ? o : {o[7:0], 8'h00});
    wr32(OFS_PC, {16'h0, pc});
    run(MODE_INDEXED);
    rd_chk(OFS_STAT, {29'h0, er, !er, 1'b0}, 32'h6);
    if (!er) begin
      rd_chk(OFS_EA, {16'h0, ea}, 32'hffff);
      rd_chk(OFS_INFO, {16'h0, pb, 4'h0, cyc}, 32'hff0f);
      rd_chk(pa, {16'h0, np}, 32'hffff);
      rd_chk(OFS_PC, {16'h0, pc + 16'(nob + 1)}, 32'hffff);
    end
    wr32(OFS_STAT, 32'h6);
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    pc = 16'h0100;
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd_chk(OFS_PAGE, 32'h0, 32'hff);
    wr32(8'h3c, $random(seed));
    rd_chk(8'h3c, 32'h0, 32'hffffffff);
    $display("test reset done");
    wr32(OFS_PAGE, 32'ha5);
    for (int i = 0; i < 4; i++) begin
      slow <= i[0];
      put_w(pc, 16'h1234);
      wr32(OFS_PC, {16'h0, pc});
      run(i[2:0]);
      rd_chk(OFS_EA, i == 3 ? 32'h1234 : i == 2 ? 32'ha512 : {16'h0, pc}, 32'hffff);
      rd_chk(OFS_PC, {16'h0, pc + (i[0] ? 16'h2 : 16'h1)}, 32'hffff);
      if (i < 2) rd_chk(OFS_OPND, i[0] ? 32'h1234 : 32'h12, i[0] ? 32'hffff : 32'hff);
    end
    $display("test plain modes done");
    acc = $random(seed);
    wr32(OFS_ACC, {16'h0, acc});
    for (int r = 0; r < 4; r++) begin
      pr[r] = $random(seed);
      p = pr[r];
      b = {1'b1, r[1:0], 5'h0};
      ix({1'b0, r[1:0], 5'h10}, 0, 16'h0, p - 16'h10, CYC_SHORT, p, 1'b0);
      ix(b | 8'h04, 0, 16'h0, p, CYC_ZERO, p, 1'b0);
    end
    ix(b | 8'h08, 1, 16'h0080, p - 16'h80, CYC_SHORT, p, 1'b0);
    ix(b | 8'h09, 2, 16'h0010 - p, 16'h0010, CYC_LONG, p, 1'b0);
    ix(b | 8'h06, 0, 16'h0, p + {{8{acc[7]}}, acc[7:0]}, CYC_SHORT, p, 1'b0);
    ix(b | 8'h05, 0, 16'h0, p + {{8{acc[15]}}, acc[15:8]}, CYC_SHORT, p, 1'b0);
    ix(b | 8'h0b, 0, 16'h0, p + {acc[7:0], acc[15:8]}, CYC_LONG, p, 1'b0);
    ix(b | 8'h00, 0, 16'h0, p, CYC_STEP1, p + 16'h1, 1'b0);
    ix(b | 8'h01, 0, 16'h0, p, CYC_STEP2, p + 16'h2, 1'b0);
    ix(b | 8'h02, 0, 16'h0, p - 16'h1, CYC_STEP1, p - 16'h1, 1'b0);
    ix(b | 8'h03, 0, 16'h0, p - 16'h2, CYC_STEP2, p - 16'h2, 1'b0);
    ix(8'hec, 1, 16'h00f0, pc + 16'h2 - 16'h10, CYC_SHORT, pr[3], 1'b0);
    ix(8'h8d, 2, 16'h8000, pc + 16'h8003, CYC_PC16, pr[0], 1'b0);
    put_w(p, 16'hc35e);
    ix(b | 8'h14, 0, 16'h0, 16'hc35e, CYC_ZERO + CYC_INDIR, p, 1'b0);
    ix(b | 8'h11, 0, 16'h0, 16'hc35e, CYC_STEP2 + CYC_INDIR, p + 16'h2, 1'b0);
    put_w(p + 16'h20, 16'h4a6b);
    ix(b | 8'h19, 2, 16'h0020, 16'h4a6b, CYC_LONG + CYC_INDIR, p, 1'b0);
    put_w(16'h2000, 16'h7e81);
    ix(8'h9f, 2, 16'h2000, 16'h7e81, CYC_EXTIND + CYC_INDIR, pr[0], 1'b0);
    ix(b | 8'h10, 0, 16'h0, 16'h0, 4'h0, p, 1'b1);
    ix(b | 8'h07, 0, 16'h0, 16'h0, 4'h0, p, 1'b1);
    $display("test indexed done");
    wr32(OFS_STACK, 32'h0f);
    rd_chk(OFS_STACK, 32'h41b, 32'h7ff);
    wr32(OFS_STACK, 32'h10f);
    rd_chk(OFS_STACK, 32'h4e4, 32'h7ff);
    $display("test stack done");
    results();
  end
endmodule // oag_core_test
`default_nettype wire
